/* File: term_decode.sv */
// resistor enable decode from the termination control fields
// assumes fields come straight from registers
`timescale 1ns/1ps
`include "ulpi_lp_cfg.svh"

module term_decode
  import ulpi_lp_pkg::*;
(
  input term_fields_s fields_in,
  output term_enables_s enables_out
);

  // =====================================================================
  // decode
  function automatic term_enables_s decode(input term_fields_s f);
    logic off;
    term_enables_s e;
    off = (f.operating_mode_field == `ULPI_OPERATING_MODE_FIELD_ALL_OFF);
    e.plus_line_pulldown_enable = f.plus_line_pull_low_ctrl & ~off;
    e.minus_line_pulldown_enable = f.minus_line_pull_low_ctrl & ~off;
    e.plus_line_pullup_enable = f.termination_select & ~f.plus_line_pull_low_ctrl
                                & ~off;
    e.high_speed_term_enable = (f.transceiver_select == `ULPI_XCVR_HS)
                               & ~f.termination_select & ~off;
    return e;
  endfunction

  always_comb begin
    enables_out = decode(fields_in);
  end

endmodule // term_decode

/* File: ulpi_link_model.sv */
// link controller model on the ulpi pins
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps

module ulpi_link_model (
  input wire logic clk_in,
  input wire logic [3:0] dev_data_in,
  input wire logic [3:0] dev_oe_in,
  output logic [3:0] data_out,
  output logic stp_out
);
  logic [3:0] link_val = 4'h0;

  initial stp_out = 1'b0;

  // =====================================================================
  // wire level: device wins where it drives, link drives the rest
  assign data_out = (dev_oe_in & dev_data_in) | (~dev_oe_in & link_val);

  // =====================================================================
  // link side actions
  task automatic drive(input logic [3:0] v);
    link_val <= v;
  endtask

  // reference clock always runs, so it is up before stp rises
  task automatic set_stp(input logic v);
    @(posedge clk_in);
    stp_out <= v;
  endtask
endmodule // ulpi_link_model

/* File: ulpi_lowpower_serial.sv */
// low-power and 3-pin serial remapping of the ulpi data bus,
// interrupt line and resistor control registers
// assumes stp and interrupt sources are synchronised here, other inputs are live
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
`include "ulpi_lp_cfg.svh"

module ulpi_lowpower_serial
  import ulpi_lp_pkg::*;
#(
  parameter int INT_W = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wr_data_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rd_data_out,
  // ulpi pins
  input wire logic stp_in,
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic [3:0] data_oe_out,
  output logic dir_out,
  output logic nxt_out,
  // analog front end
  input wire logic [1:0] line_state_in,
  input wire logic rx_serial_diff_line_in,
  input wire logic rx_se0_in,
  input wire logic [INT_W-1:0] int_src_in,
  output logic tx_enable_out,
  output logic tx_serial_diff_line_out,
  output logic tx_se0_out,
  output logic suspend_out,
  output logic clock_run_out,
  output term_enables_s term_en_out
);

  // =====================================================================
  // state
  typedef struct packed {
    mode_e mode;
    logic phy_awake_ctrl;
    logic three_wire_serial_select;
    logic clock_keep_running;
    term_fields_s term;
    logic [INT_W-1:0] int_mask;
    logic [2:0] stp_sync;
    logic stp_stab;
    logic [2:0][INT_W-1:0] int_sync;
    logic [INT_W-1:0] int_stab;
    logic [INT_W-1:0] int_snap;
    logic [INT_W-1:0] int_latch;
    logic [3:0] rxcmd;
    logic [7:0] rd_data;
  } state_s;

  state_s state_reg;
  state_s state_next;

  logic [INT_W-1:0] int_agree;
  logic [INT_W-1:0] int_stab_new;
  logic int_line;
  logic rxcmd_due;
  logic tx_en;

  // remapped bus modes
  function automatic logic remapped(input mode_e m);
    return (m == MODE_LOWPWR) || (m == MODE_SERIAL);
  endfunction

  // =====================================================================
  // synchronised inputs and interrupt tracking
  always_comb begin
    int_agree = ~(state_reg.int_sync[1] ^ state_reg.int_sync[2]);
    int_stab_new = (state_reg.int_stab & ~int_agree) |
                   (state_reg.int_sync[2] & int_agree);
    int_line = |(state_reg.int_latch & state_reg.int_mask);
    rxcmd_due = |(state_reg.int_latch & state_reg.int_mask &
                  (state_reg.int_stab ^ state_reg.int_snap));
  end

  // =====================================================================
  // next state
  always_comb begin
    state_next = state_reg;
    if (ce_in) begin
      state_next.stp_sync = {state_reg.stp_sync[1:0], stp_in};
      if (state_reg.stp_sync[1] == state_reg.stp_sync[2]) begin
        state_next.stp_stab = state_reg.stp_sync[2];
      end
      state_next.int_sync[0] = int_src_in;
      state_next.int_sync[1] = state_reg.int_sync[0];
      state_next.int_sync[2] = state_reg.int_sync[1];
      state_next.int_stab = int_stab_new;
      state_next.rd_data = 8'h00;

      // register writes
      if (reg_wr_in) begin
        case (reg_addr_in)
          `ULPI_REG_FUNC_CTRL: begin
            state_next.phy_awake_ctrl = reg_wr_data_in[`ULPI_PHY_AWAKE_BIT];
          end
          `ULPI_REG_IFACE_CTRL: begin
            state_next.three_wire_serial_select = reg_wr_data_in[`ULPI_THREE_WIRE_BIT];
            state_next.clock_keep_running = reg_wr_data_in[`ULPI_KEEP_RUN_BIT];
          end
          `ULPI_REG_TERM_CTRL: begin
            state_next.term = term_fields_s'(reg_wr_data_in[6:0]);
          end
          `ULPI_REG_INT_MASK: begin
            state_next.int_mask = reg_wr_data_in[INT_W-1:0];
          end
          default: begin
          end
        endcase
      end

      // register reads, data in the next cycle only
      if (reg_rd_in) begin
        case (reg_addr_in)
          `ULPI_REG_FUNC_CTRL: begin
            state_next.rd_data[`ULPI_PHY_AWAKE_BIT] = state_reg.phy_awake_ctrl;
          end
          `ULPI_REG_IFACE_CTRL: begin
            state_next.rd_data[`ULPI_THREE_WIRE_BIT] = state_reg.three_wire_serial_select;
            state_next.rd_data[`ULPI_KEEP_RUN_BIT] = state_reg.clock_keep_running;
          end
          `ULPI_REG_TERM_CTRL: begin
            state_next.rd_data[6:0] = state_reg.term;
          end
          `ULPI_REG_INT_MASK: begin
            state_next.rd_data[INT_W-1:0] = state_reg.int_mask;
          end
          `ULPI_REG_STATUS: begin
            state_next.rd_data[`ULPI_STATUS_MODE_MSB:`ULPI_STATUS_MODE_LSB] = state_reg.mode;
            state_next.rd_data[INT_W-1:0] = state_reg.int_latch;
          end
          default: begin
          end
        endcase
      end

      // mode sequencing
      case (state_reg.mode)
        MODE_SYNC: begin
          if (!state_reg.stp_stab) begin
            if (!state_reg.phy_awake_ctrl) begin
              state_next.mode = MODE_LOWPWR;
              state_next.int_snap = int_stab_new;
              state_next.int_latch = '0;
            end else if (state_reg.three_wire_serial_select) begin
              state_next.mode = MODE_SERIAL;
              state_next.int_snap = int_stab_new;
              state_next.int_latch = '0;
            end
          end
        end
        MODE_LOWPWR, MODE_SERIAL: begin
          state_next.int_latch = state_reg.int_latch | (int_stab_new ^ state_reg.int_stab);
          if (state_reg.stp_stab) begin
            // hardware wake wins over a write in the same cycle
            state_next.phy_awake_ctrl = 1'b1;
            state_next.three_wire_serial_select = 1'b0;
            state_next.rxcmd = {int_line, 1'b0, line_state_in};
            state_next.mode = rxcmd_due ? MODE_WAKE : MODE_SYNC;
          end
        end
        MODE_WAKE: begin
          state_next.int_latch = '0;
          state_next.mode = MODE_SYNC;
        end
        default: begin
          state_next.mode = MODE_SYNC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= '0;
      state_reg.phy_awake_ctrl <= `ULPI_PHY_AWAKE_RST;
      state_reg.three_wire_serial_select <= `ULPI_THREE_WIRE_RST;
      state_reg.clock_keep_running <= `ULPI_KEEP_RUN_RST;
      state_reg.term <= `ULPI_TERM_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // =====================================================================
  // pin remapping
  always_comb begin
    tx_en = (state_reg.mode == MODE_SERIAL) & data_in[0];
    data_out = 4'h0;
    data_oe_out = 4'h0;
    case (state_reg.mode)
      MODE_LOWPWR: begin
        data_oe_out = 4'hf;
        data_out[1:0] = line_state_in;
        data_out[2] = 1'b0;
        data_out[3] = int_line;
      end
      MODE_SERIAL: begin
        data_oe_out = {1'b1, ~tx_en, ~tx_en, 1'b0};
        data_out[1] = rx_serial_diff_line_in;
        data_out[2] = rx_se0_in;
        data_out[3] = int_line;
      end
      MODE_WAKE: begin
        data_oe_out = 4'hf;
        data_out = state_reg.rxcmd;
      end
      default: begin
      end
    endcase
  end

  assign dir_out = state_reg.mode != MODE_SYNC;
  assign nxt_out = 1'b0;
  assign tx_enable_out = tx_en;
  assign tx_serial_diff_line_out = tx_en & data_in[1];
  assign tx_se0_out = tx_en & data_in[2];
  assign suspend_out = state_reg.mode == MODE_LOWPWR;
  assign clock_run_out = !remapped(state_reg.mode) ||
                         (state_reg.mode == MODE_SERIAL &&
                          state_reg.clock_keep_running);
  assign reg_rd_data_out = state_reg.rd_data;

  term_decode u_term_decode (
    .fields_in(state_reg.term),
    .enables_out(term_en_out)
  );

  // =====================================================================
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_wake_req;
    ce_in && remapped(state_reg.mode) && state_reg.stp_stab;
  endsequence

  sequence s_back_to_bus;
    state_reg.mode == MODE_SYNC || state_reg.mode == MODE_WAKE;
  endsequence

  property p_dir_hold;
    remapped(state_reg.mode) |-> dir_out && !nxt_out;
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("dir dropped or nxt used");

  property p_nxt_idle;
    $rose(dir_out) |-> !nxt_out [*2];
  endproperty
  a_nxt_idle: assert property (p_nxt_idle) else $error("nxt driven while remapped");

  property p_wake_exit;
    s_wake_req |=> s_back_to_bus;
  endproperty
  a_wake_exit: assert property (p_wake_exit) else $error("stp did not end remap");

  property p_wake_rxcmd;
    s_wake_req ##1 (state_reg.mode == MODE_WAKE) |->
      dir_out && data_oe_out == 4'hf ##1 (state_reg.mode == MODE_SYNC || !ce_in);
  endproperty
  a_wake_rxcmd: assert property (p_wake_rxcmd) else $error("rxcmd not one cycle");

  property p_wake_due;
    s_wake_req and rxcmd_due |=> state_reg.mode == MODE_WAKE;
  endproperty
  a_wake_due: assert property (p_wake_due) else $error("pending change lost rxcmd");

  property p_lp_map;
    state_reg.mode == MODE_LOWPWR |->
      data_oe_out == 4'hf && data_out[1:0] == line_state_in && !data_out[2];
  endproperty
  a_lp_map: assert property (p_lp_map) else $error("low-power mapping wrong");

  property p_int_line;
    remapped(state_reg.mode) |->
      data_out[3] == |(state_reg.int_latch & state_reg.int_mask) && data_oe_out[3];
  endproperty
  a_int_line: assert property (p_int_line) else $error("interrupt line wrong");

  property p_serial_tx;
    state_reg.mode == MODE_SERIAL && data_in[0] |->
      tx_serial_diff_line_out == data_in[1] && tx_se0_out == data_in[2] &&
      data_oe_out[2:0] == 3'b000;
  endproperty
  a_serial_tx: assert property (p_serial_tx) else $error("serial transmit wrong");

  property p_serial_rx;
    state_reg.mode == MODE_SERIAL && !data_in[0] |->
      data_out[2:1] == {rx_se0_in, rx_serial_diff_line_in} && data_oe_out[2:1] == 2'b11 &&
      !tx_enable_out;
  endproperty
  a_serial_rx: assert property (p_serial_rx) else $error("serial receive wrong");

  property p_keep_clock;
    state_reg.mode == MODE_SERIAL |-> clock_run_out == state_reg.clock_keep_running;
  endproperty
  a_keep_clock: assert property (p_keep_clock) else $error("clock keep bit ignored");

  property p_all_off;
    state_reg.term.operating_mode_field == `ULPI_OPERATING_MODE_FIELD_ALL_OFF |-> term_en_out == '0;
  endproperty
  a_all_off: assert property (p_all_off) else $error("resistors on in all-off mode");

  property p_term_write;
    ce_in && reg_wr_in && reg_addr_in == `ULPI_REG_TERM_CTRL &&
    reg_wr_data_in[3:2] != `ULPI_OPERATING_MODE_FIELD_ALL_OFF |=>
      term_en_out.plus_line_pulldown_enable == $past(reg_wr_data_in[1]) &&
      term_en_out.minus_line_pulldown_enable == $past(reg_wr_data_in[0]);
  endproperty
  a_term_write: assert property (p_term_write) else $error("pulldown not from write");

  property p_pullup;
    term_en_out.plus_line_pullup_enable |->
      state_reg.term.termination_select && !state_reg.term.plus_line_pull_low_ctrl;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pullup without cause");

  property p_hs_term;
    term_en_out.high_speed_term_enable |->
      state_reg.term.transceiver_select == `ULPI_XCVR_HS &&
      !state_reg.term.termination_select;
  endproperty
  a_hs_term: assert property (p_hs_term) else $error("hs termination without cause");

  property p_serial_in;
    state_reg.mode == MODE_SERIAL |-> !data_oe_out[0] && tx_enable_out == data_in[0];
  endproperty
  a_serial_in: assert property (p_serial_in) else $error("serial data0 not an input");

  property p_pulldown;
    state_reg.term.operating_mode_field != `ULPI_OPERATING_MODE_FIELD_ALL_OFF |->
      term_en_out.plus_line_pulldown_enable == state_reg.term.plus_line_pull_low_ctrl &&
      term_en_out.minus_line_pulldown_enable == state_reg.term.minus_line_pull_low_ctrl;
  endproperty
  a_pulldown: assert property (p_pulldown) else $error("pulldown mismatch");

  property p_exit_clear;
    s_wake_req |=> state_reg.phy_awake_ctrl && !state_reg.three_wire_serial_select;
  endproperty
  a_exit_clear: assert property (p_exit_clear) else $error("remap bits kept");

endmodule // ulpi_lowpower_serial

/* File: ulpi_lowpower_serial_tb_top.sv */
// self-checking bench for the low-power, serial and termination block
// assumes registers at 00..04 and the link model on the ulpi pins
`timescale 1ns/1ps
`include "ulpi_lp_cfg.svh"

module ulpi_lowpower_serial_tb_top
  import ulpi_lp_pkg::*;
();
  logic clk_in;
  logic nrst_in;
  logic ce;
  logic [7:0] reg_addr;
  logic [7:0] reg_wr_data;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rd_data;
  logic stp;
  logic [3:0] data_in;
  logic [3:0] data_out;
  logic [3:0] data_oe;
  logic dir;
  logic nxt;
  logic [1:0] line_state;
  logic rx_diff;
  logic rx_se0;
  logic [3:0] int_src;
  logic tx_en;
  logic tx_diff;
  logic tx_se0;
  logic suspend;
  logic clock_run;
  term_enables_s term_en;
  int fail_count = 0;
  int n_compared = 0;
  logic [7:0] rd_val;
  // {fields, enables}
  logic [10:0] rows [11] = '{{7'h07, 4'h0}, {7'h77, 4'h0}, {7'h23, 4'h6}, {7'h0b, 4'h7},
    {7'h73, 4'h6}, {7'h53, 4'h6}, {7'h18, 4'h8}, {7'h00, 4'h1}, {7'h30, 4'h8},
    {7'h19, 4'ha}, {7'h01, 4'h3}};
  logic [7:0] rst_vals [6] = '{8'h01, 8'h00, 8'h23, 8'h00, 8'h00, 8'h00};

  always #12.5 clk_in = ~clk_in;

  ulpi_lowpower_serial #(.INT_W(4)) u_ulpi_lowpower_serial (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce),
    .reg_addr_in(reg_addr), .reg_wr_data_in(reg_wr_data), .reg_wr_in(reg_wr),
    .reg_rd_in(reg_rd), .reg_rd_data_out(reg_rd_data),
    .stp_in(stp), .data_in(data_in), .data_out(data_out), .data_oe_out(data_oe),
    .dir_out(dir), .nxt_out(nxt), .line_state_in(line_state),
    .rx_serial_diff_line_in(rx_diff), .rx_se0_in(rx_se0), .int_src_in(int_src),
    .tx_enable_out(tx_en), .tx_serial_diff_line_out(tx_diff), .tx_se0_out(tx_se0),
    .suspend_out(suspend), .clock_run_out(clock_run), .term_en_out(term_en)
  );

  ulpi_link_model u_ulpi_link_model (
    .clk_in(clk_in), .dev_data_in(data_out), .dev_oe_in(data_oe),
    .data_out(data_in), .stp_out(stp)
  );

  // =====================================================================
  // helpers
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk_in);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_in);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rd_data;
  endtask

  // sel 0 waits on dir, sel 1 on suspend
  task automatic wait_sig(input int sel, input logic val);
    for (int i = 0; i < 30; i++) begin
      @(posedge clk_in);
      #1;
      if ((sel == 1 ? suspend : dir) === val) return;
    end
    fail_count++;
    $display("[ERR] wait on %0d for %b ran out", sel, val);
    close_out();
  endtask

  // =====================================================================
  // main sequence
  initial begin
    clk_in = 1'b0;
    nrst_in = 1'b0;
    ce = 1'b1;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    line_state = 2'b00;
    rx_diff = 1'b0;
    rx_se0 = 1'b0;
    int_src = 4'h0;
    @(posedge clk_in);
    #1;
    chk("reset enables", 8'(term_en), 8'h06);
    chk("reset dir", 8'(dir), 8'h00);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(i));
      chk("reset value", rd_val, rst_vals[i]);
      @(posedge clk_in);
      #1;
      chk("read data one cycle", reg_rd_data, 8'h00);
    end
    // resistor decode table
    for (int i = 0; i < 11; i++) begin
      wr(8'h02, {1'b0, rows[i][10:4]});
      chk("enables", 8'(term_en), 8'(rows[i][3:0]));
      rd(8'h02);
      chk("term readback", rd_val, {1'b0, rows[i][10:4]});
    end
    // low-power with a held interrupt change
    wr(8'h03, 8'h0f);
    @(posedge clk_in);
    line_state <= 2'b10;
    wr(8'h00, 8'h00);
    wait_sig(0, 1'b1);
    chk("lp pins", {suspend, clock_run, nxt, 1'b0, data_oe}, 8'h8f);
    chk("lp data", 8'(data_out), 8'h02);
    @(posedge clk_in);
    line_state <= 2'b01;
    #1;
    chk("lp line", 8'(data_out[1:0]), 8'h01);
    @(posedge clk_in);
    int_src <= 4'h1;
    repeat (5) @(posedge clk_in);
    #1;
    chk("lp int", 8'(data_out[3]), 8'h01);
    wr(8'h03, 8'h00);
    chk("lp int masked", 8'(data_out[3]), 8'h00);
    wr(8'h03, 8'h0f);
    rd(8'h04);
    chk("status lp", rd_val, 8'h41);
    u_ulpi_link_model.set_stp(1'b1);
    wait_sig(1, 1'b0);
    chk("wake dir", 8'(dir), 8'h01);
    chk("wake rxcmd", {data_oe, data_out}, 8'hf9);
    @(posedge clk_in);
    #1;
    chk("sync dir", 8'(dir), 8'h00);
    u_ulpi_link_model.set_stp(1'b0);
    rd(8'h00);
    chk("awake restored", rd_val, 8'h01);
    repeat (3) @(posedge clk_in);
    // low-power with no change: direct exit
    wr(8'h00, 8'h00);
    wait_sig(0, 1'b1);
    u_ulpi_link_model.set_stp(1'b1);
    wait_sig(1, 1'b0);
    chk("direct exit dir", 8'(dir), 8'h00);
    u_ulpi_link_model.set_stp(1'b0);
    repeat (4) @(posedge clk_in);
    // 3-pin serial, receive then transmit
    wr(8'h01, 8'h03);
    wait_sig(0, 1'b1);
    chk("serial pins", {suspend, clock_run, nxt, 5'h00}, 8'h40);
    @(posedge clk_in);
    rx_diff <= 1'b1;
    rx_se0 <= 1'b1;
    #1;
    chk("rx oe", 8'(data_oe), 8'h0e);
    chk("rx data", 8'({tx_en, data_out[2:1]}), 8'h03);
    @(posedge clk_in);
    rx_diff <= 1'b0;
    u_ulpi_link_model.drive(4'h3);
    #1;
    chk("tx oe", 8'(data_oe), 8'h08);
    chk("tx dat", 8'({tx_en, tx_diff, tx_se0}), 8'h06);
    @(posedge clk_in);
    u_ulpi_link_model.drive(4'h5);
    #1;
    chk("tx se0", 8'({tx_en, tx_diff, tx_se0}), 8'h05);
    @(posedge clk_in);
    u_ulpi_link_model.drive(4'h0);
    wr(8'h01, 8'h01);
    chk("clock stop", 8'(clock_run), 8'h00);
    u_ulpi_link_model.set_stp(1'b1);
    wait_sig(0, 1'b0);
    u_ulpi_link_model.set_stp(1'b0);
    rd(8'h01);
    chk("serial cleared", rd_val, 8'h00);
    // clock enable low refuses a strobe
    @(posedge clk_in);
    ce <= 1'b0;
    wr(8'h01, 8'h01);
    @(posedge clk_in);
    ce <= 1'b1;
    rd(8'h01);
    chk("ce low write", rd_val, 8'h00);
    // reset in mid-run, from low-power
    wr(8'h00, 8'h00);
    wait_sig(0, 1'b1);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    #1;
    chk("mid reset pins", 8'({dir, data_oe}), 8'h00);
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(8'h00);
    chk("mid reset awake", rd_val, 8'h01);
    chk("mid reset enables", 8'(term_en), 8'h06);
    close_out();
  end
endmodule // ulpi_lowpower_serial_tb_top

/* File: ulpi_lp_cfg.svh */
// constants for the low-power, 3-pin serial and termination block
// assumes a single 40 MHz clock and a plain register port
//
// Notes on behaviour
// - stp ends low-power, bus returns to normal
// - send rxcmd if suspended change persists
// - low-power data0/1 carry line state combinationally
// - low-power data2 held driven low
// - data3 is unmasked interrupt, active high
// - stp ends serial mode, bus returns normal
// - keep clock running in serial when asked
// - serial data0 is link transmit enable
// - serial data1 transmits or receives differential data
// - serial data2 transmits or receives se0
// - operating mode 01 switches all resistors off
// - plus line pulldown follows its control bit
// - minus line pulldown follows its control bit
// - pullup only with termination, no plus pulldown
// - hs termination only xcvr 00, term 0
// - dir held high in low-power and serial
// - stp held high wakes to synchronous mode
// - nxt unused in low-power and serial
`ifndef ULPI_LP_CFG_SVH
`define ULPI_LP_CFG_SVH

// =====================================================================
// register offsets
`define ULPI_REG_FUNC_CTRL 8'h00
`define ULPI_REG_IFACE_CTRL 8'h01
`define ULPI_REG_TERM_CTRL 8'h02
`define ULPI_REG_INT_MASK 8'h03
`define ULPI_REG_STATUS 8'h04

// =====================================================================
// field positions
`define ULPI_PHY_AWAKE_BIT 0
`define ULPI_THREE_WIRE_BIT 0
`define ULPI_KEEP_RUN_BIT 1
`define ULPI_STATUS_MODE_MSB 7
`define ULPI_STATUS_MODE_LSB 6

// =====================================================================
// reset values and field codes
`define ULPI_PHY_AWAKE_RST 1'b1
`define ULPI_THREE_WIRE_RST 1'b0
`define ULPI_KEEP_RUN_RST 1'b0
`define ULPI_TERM_RST 7'h23
`define ULPI_OPERATING_MODE_FIELD_ALL_OFF 2'b01
`define ULPI_XCVR_HS 2'b00

`endif

/* File: ulpi_lp_pkg.sv */
// types shared by the low-power and serial block and its decoder
// assumes the constants header is included by each user
package ulpi_lp_pkg;

  // =====================================================================
  // bus modes, gray along sync -> low-power -> sync and serial -> wake -> sync
  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_LOWPWR = 2'b01,
    MODE_SERIAL = 2'b11,
    MODE_WAKE = 2'b10
  } mode_e;

  // =====================================================================
  // termination control fields, msb first
  typedef struct packed {
    logic [1:0] transceiver_select;
    logic termination_select;
    logic [1:0] operating_mode_field;
    logic plus_line_pull_low_ctrl;
    logic minus_line_pull_low_ctrl;
  } term_fields_s;

  // resistor enables to the analog front end
  typedef struct packed {
    logic plus_line_pullup_enable;
    logic plus_line_pulldown_enable;
    logic minus_line_pulldown_enable;
    logic high_speed_term_enable;
  } term_enables_s;

endpackage
